// ==== common/sfcd_pkg.sv ====
// shared constants and types of the serial flash command decoder
package sfcd_pkg;

    // ****************************************************************
    // opcodes
    // ****************************************************************
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_ARM = 8'h06;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
    localparam logic [7:0] OP_DUAL_READ = 8'h3B;
    localparam logic [7:0] OP_UID_READ = 8'h4B;
    localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
    localparam logic [7:0] OP_CHIP_WIPE_B = 8'h60;
    localparam logic [7:0] OP_MFR_DEV_ID = 8'h90;
    localparam logic [7:0] OP_STD_ID = 8'h9F;
    localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
    localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] OP_CHIP_WIPE_A = 8'hC7;
    localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;

    // ****************************************************************
    // status byte layout and reset values
    // ****************************************************************
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_GUARD_LSB = 2;
    localparam int ST_GUARD_MSB = 4;
    localparam int ST_LOCK_BIT = 7;
    localparam logic [2:0] ST_GUARD_RST = 3'h0;
    localparam logic ST_LOCK_RST = 1'b0;
    localparam logic ST_LATCH_RST = 1'b0;

    // ****************************************************************
    // byte counts of the instruction frames
    // ****************************************************************
    localparam logic [2:0] BYTES_OPCODE = 3'h1;
    localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
    localparam logic [2:0] BYTES_ADDR_HDR = 3'h4;
    localparam logic [2:0] BYTES_DUMMY_HDR = 3'h5;
    localparam logic [2:0] BYTES_PAGE_MIN = 3'h5;
    localparam logic [2:0] BYTES_NONE = 3'h0;
    localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
    localparam logic [3:0] UID_LAST_BYTE = 4'hF;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        OPK_STATUS_WRITE,
        OPK_PAGE,
        OPK_SECTOR,
        OPK_HALF_BLOCK,
        OPK_BLOCK,
        OPK_CHIP
    } sfcd_op_e;

    typedef enum logic [1:0] {
        MODE_READY,
        MODE_BUSY,
        MODE_POWER_DOWN
    } sfcd_mode_e;

endpackage : sfcd_pkg

// ==== rtl/sfcd_sync.sv ====
// two flip-flop synchroniser for a group of slow levels
`timescale 1ns/1ps
module sfcd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : sfcd_sync

// ==== rtl/sfcd_busy_timer.sv ====
// self-timed cycle counter standing in for the program and erase engine
`timescale 1ns/1ps
module sfcd_busy_timer #(
    parameter int CNT_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [CNT_W-1:0] cycles_i,
    output logic busy_o,
    output logic done_o
);
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else if (start_i)
        begin
            cnt_q <= cycles_i;
            busy_o <= 1'b1;
            done_o <= 1'b0;
        end
        else if (busy_o && cnt_q <= CNT_W'(1))
        begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
        end
        else
        begin
            cnt_q <= busy_o ? cnt_q - CNT_W'(1) : cnt_q;
            done_o <= 1'b0;
        end
    end
endmodule : sfcd_busy_timer

// ==== rtl/sfcd_top.sv ====
// serial flash command front end: link shifter, reply path and command executor
`timescale 1ns/1ps
module sfcd_top #(
    parameter logic [7:0] MFR_ID = 8'hA1,       // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h7B,       // arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h40,     // arbitrary value
    parameter logic [7:0] CAPACITY = 8'h15,     // arbitrary value
    parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210, // arbitrary value
    parameter int TIMER_W = 16,
    parameter int T_STATUS_CYC = 200,
    parameter int T_PAGE_CYC = 400,
    parameter int T_SECTOR_CYC = 800,
    parameter int T_BLOCK_CYC = 1600,
    parameter int T_CHIP_CYC = 3200
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic serial_in_i,
    output logic io0_o,
    output logic io0_oe_o,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic [23:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output logic op_start_o,
    output sfcd_pkg::sfcd_op_e op_kind_o,
    output logic [23:0] op_addr_o,
    output logic [7:0] status_byte_o,
    output logic power_down_o
);
    import sfcd_pkg::*;

    // ****************************************************************
    // link domain: frame start and shifter
    // ****************************************************************
    logic fresh_q;
    logic [2:0] bit_cnt_q;
    logic [2:0] bit_cnt_d;
    logic [2:0] byte_cnt_q;
    logic [2:0] byte_cnt_d;
    logic [31:0] sh_q;
    logic [31:0] sh_d;
    logic byte_done;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    logic [7:0] wdata_q;
    logic frame_tgl_q;
    logic [2:0] hdr_len;
    logic is_dual;
    logic in_data;
    logic [23:0] addr_src;
    logic [23:0] rd_addr_q;
    logic [1:0] dcnt_q;
    logic [8:0] link_view;
    logic [7:0] status_l;
    logic pd_l;
    logic busy_l;

    // held high by select, so the first edge of a frame always restarts counting
    always_ff @(posedge sclk_i or posedge cs_n_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            fresh_q <= 1'b1;
        else if (cs_n_i)
            fresh_q <= 1'b1;
        else
            fresh_q <= 1'b0;
    end

    always_comb
    begin
        sh_d = {sh_q[30:0], serial_in_i};
        bit_cnt_d = fresh_q ? 3'h1 : 3'(bit_cnt_q + 3'h1);
        byte_done = (bit_cnt_d == 3'h0);
        byte_cnt_d = fresh_q ? 3'h0 : byte_cnt_q;
        if (byte_done && byte_cnt_d != BYTE_CNT_MAX)
            byte_cnt_d = 3'(byte_cnt_d + 3'h1);
        addr_src = (byte_cnt_d == BYTES_ADDR_HDR) ? sh_d[23:0] : addr_q;
    end

    always_ff @(posedge sclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            sh_q <= 32'h0;
            frame_tgl_q <= 1'b0;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_d;
            byte_cnt_q <= byte_cnt_d;
            sh_q <= sh_d;
            frame_tgl_q <= fresh_q ? ~frame_tgl_q : frame_tgl_q;
        end
    end

    // fields of the frame, left standing after select rises for the executor
    always_ff @(posedge sclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            opcode_q <= 8'h00;
            addr_q <= 24'h0;
            wdata_q <= 8'h00;
        end
        else if (byte_done)
        begin
            if (byte_cnt_d == BYTES_OPCODE)
                opcode_q <= sh_d[7:0];
            if (byte_cnt_d == BYTES_STATUS_WRITE)
                wdata_q <= sh_d[7:0];
            if (byte_cnt_d == BYTES_ADDR_HDR)
                addr_q <= sh_d[23:0];
        end
    end

    // ****************************************************************
    // link domain: reply framing
    // ****************************************************************
    always_comb
    begin
        case (opcode_q)
            OP_RD_STATUS, OP_STD_ID: hdr_len = BYTES_OPCODE;
            OP_READ, OP_RELEASE_ID, OP_MFR_DEV_ID: hdr_len = BYTES_ADDR_HDR;
            OP_FAST_READ, OP_DUAL_READ, OP_UID_READ: hdr_len = BYTES_DUMMY_HDR;
            default: hdr_len = BYTES_NONE;
        endcase
        is_dual = (opcode_q == OP_DUAL_READ);
        in_data = !fresh_q && hdr_len != BYTES_NONE && byte_cnt_q >= hdr_len;
    end

    // read pointer: array address, id byte parity or unique id byte index
    always_ff @(posedge sclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rd_addr_q <= 24'h0;
            dcnt_q <= 2'h0;
        end
        else if (byte_done && hdr_len >= BYTES_ADDR_HDR && byte_cnt_d == hdr_len && !in_data)
        begin
            rd_addr_q <= (opcode_q == OP_UID_READ) ? 24'h0 : addr_src;
            dcnt_q <= 2'h0;
        end
        else if (in_data && is_dual)
        begin
            dcnt_q <= 2'(dcnt_q + 2'h1);
            if (dcnt_q == 2'h3)
                rd_addr_q <= 24'(rd_addr_q + 24'h1);
        end
        else if (in_data && byte_done)
            rd_addr_q <= 24'(rd_addr_q + 24'h1);
    end

    assign rd_addr_o = rd_addr_q;

    // bits may skew by one edge on a change; a poll simply reads again
    sfcd_sync #(
        .WIDTH(9),
        .RST_VAL(9'h000)
    ) u_sync_view (
        .clk_i(sclk_i),
        .rst_b_i(rst_b_i),
        .d_i({power_down_o, status_byte_o}),
        .q_o(link_view)
    );

    assign pd_l = link_view[8];
    assign status_l = link_view[7:0];
    assign busy_l = status_l[ST_BUSY_BIT];

    logic [7:0] out_byte;
    logic out_en;
    int uid_pos;

    always_comb
    begin
        uid_pos = 8 * (15 - int'(rd_addr_q[3:0]));
        case (opcode_q)
            OP_RD_STATUS: out_byte = status_l;
            OP_STD_ID:
            begin
                if (byte_cnt_q == 3'h1)
                    out_byte = MFR_ID;
                else if (byte_cnt_q == 3'h2)
                    out_byte = MEM_TYPE;
                else if (byte_cnt_q == 3'h3)
                    out_byte = CAPACITY;
                else
                    out_byte = 8'h00;
            end
            OP_RELEASE_ID: out_byte = DEV_ID;
            OP_MFR_DEV_ID: out_byte = rd_addr_q[0] ? DEV_ID : MFR_ID;
            OP_UID_READ: out_byte = UNIQUE_ID[uid_pos +: 8];
            default: out_byte = rd_data_i;
        endcase
        // busy serves only read-status; power-down serves only read-status and the release
        if (opcode_q == OP_RD_STATUS)
            out_en = in_data;
        else if (pd_l)
            out_en = in_data && opcode_q == OP_RELEASE_ID;
        else
            out_en = in_data && !busy_l;
    end

    // outputs change on the falling edge and float as soon as select rises
    always_ff @(negedge sclk_i or posedge cs_n_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
            io0_o <= 1'b0;
            io0_oe_o <= 1'b0;
        end
        else if (cs_n_i)
        begin
            serial_out_oe_o <= 1'b0;
            io0_oe_o <= 1'b0;
        end
        else if (is_dual)
        begin
            serial_out_o <= out_byte[{~dcnt_q, 1'b1}];
            io0_o <= out_byte[{~dcnt_q, 1'b0}];
            serial_out_oe_o <= out_en;
            io0_oe_o <= out_en;
        end
        else
        begin
            serial_out_o <= out_byte[~bit_cnt_q];
            serial_out_oe_o <= out_en;
            io0_oe_o <= 1'b0;
        end
    end

    // ****************************************************************
    // system domain: frame end detection
    // ****************************************************************
    logic [1:0] frame_s;
    logic cs_s_d_q;
    logic tgl_seen_q;
    logic frame_end;

    sfcd_sync #(
        .WIDTH(2),
        .RST_VAL(2'h1)
    ) u_sync_frame (
        .clk_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .d_i({frame_tgl_q, cs_n_i}),
        .q_o(frame_s)
    );

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cs_s_d_q <= 1'b1;
            tgl_seen_q <= 1'b0;
        end
        else
        begin
            cs_s_d_q <= frame_s[0];
            if (frame_s[0] && !cs_s_d_q)
                tgl_seen_q <= frame_s[1];
        end
    end

    // frame fields are quiet here: the link clock stops once select is high
    assign frame_end = frame_s[0] && !cs_s_d_q && (frame_s[1] != tgl_seen_q);

    // ****************************************************************
    // system domain: command execution
    // ****************************************************************
    sfcd_mode_e mode_q;
    logic latch_q;
    logic lock_q;
    logic [2:0] guard_q;
    logic aligned;
    logic arm_set;
    logic arm_clr;
    logic enter_pd;
    logic leave_pd;
    logic start_op;
    sfcd_op_e kind;
    logic [TIMER_W-1:0] cyc;
    logic timer_busy;
    logic timer_done;

    always_comb
    begin
        aligned = (bit_cnt_q == 3'h0) && (byte_cnt_q != 3'h0);
        arm_set = 1'b0;
        arm_clr = 1'b0;
        enter_pd = 1'b0;
        leave_pd = frame_end && mode_q == MODE_POWER_DOWN && opcode_q == OP_RELEASE_ID;
        start_op = 1'b0;
        kind = OPK_CHIP;
        if (frame_end && mode_q == MODE_READY && aligned)
        begin
            case (opcode_q)
                OP_WRITE_ARM: arm_set = (byte_cnt_q == BYTES_OPCODE);
                OP_WRITE_DISARM: arm_clr = (byte_cnt_q == BYTES_OPCODE);
                OP_POWER_DOWN: enter_pd = (byte_cnt_q == BYTES_OPCODE);
                OP_STATUS_WRITE:
                begin
                    start_op = latch_q && byte_cnt_q >= BYTES_STATUS_WRITE;
                    kind = OPK_STATUS_WRITE;
                end
                OP_PAGE_WRITE:
                begin
                    start_op = latch_q && byte_cnt_q >= BYTES_PAGE_MIN;
                    kind = OPK_PAGE;
                end
                OP_SECTOR_WIPE:
                begin
                    start_op = latch_q && byte_cnt_q >= BYTES_ADDR_HDR;
                    kind = OPK_SECTOR;
                end
                OP_HALF_BLOCK_WIPE, OP_BLOCK_WIPE:
                begin
                    start_op = latch_q && byte_cnt_q >= BYTES_ADDR_HDR;
                    kind = (opcode_q == OP_BLOCK_WIPE) ? OPK_BLOCK : OPK_HALF_BLOCK;
                end
                OP_CHIP_WIPE_A, OP_CHIP_WIPE_B:
                begin
                    start_op = latch_q && byte_cnt_q == BYTES_OPCODE;
                    kind = OPK_CHIP;
                end
                default: start_op = 1'b0;
            endcase
        end
        case (kind)
            OPK_STATUS_WRITE: cyc = TIMER_W'(T_STATUS_CYC);
            OPK_PAGE: cyc = TIMER_W'(T_PAGE_CYC);
            OPK_SECTOR: cyc = TIMER_W'(T_SECTOR_CYC);
            OPK_HALF_BLOCK, OPK_BLOCK: cyc = TIMER_W'(T_BLOCK_CYC);
            default: cyc = TIMER_W'(T_CHIP_CYC);
        endcase
    end

    sfcd_busy_timer #(
        .CNT_W(TIMER_W)
    ) u_timer (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .start_i(start_op),
        .cycles_i(cyc),
        .busy_o(timer_busy),
        .done_o(timer_done)
    );

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            mode_q <= MODE_READY;
        else
        begin
            case (mode_q)
                MODE_READY:
                begin
                    if (start_op)
                        mode_q <= MODE_BUSY;
                    else if (enter_pd)
                        mode_q <= MODE_POWER_DOWN;
                end
                MODE_BUSY:
                begin
                    if (timer_done)
                        mode_q <= MODE_READY;
                end
                MODE_POWER_DOWN:
                begin
                    if (leave_pd)
                        mode_q <= MODE_READY;
                end
                default: mode_q <= MODE_READY;
            endcase
        end
    end

    // arm and disarm only ever occur in ready mode, so they never meet done
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            latch_q <= ST_LATCH_RST;
        else if (arm_set)
            latch_q <= 1'b1;
        else if (arm_clr || timer_done)
            latch_q <= 1'b0;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            lock_q <= ST_LOCK_RST;
            guard_q <= ST_GUARD_RST;
        end
        else if (start_op && kind == OPK_STATUS_WRITE)
        begin
            lock_q <= wdata_q[ST_LOCK_BIT];
            guard_q <= wdata_q[ST_GUARD_MSB:ST_GUARD_LSB];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            op_start_o <= 1'b0;
            op_kind_o <= OPK_CHIP;
            op_addr_o <= 24'h0;
        end
        else
        begin
            op_start_o <= start_op && kind != OPK_STATUS_WRITE;
            if (start_op)
            begin
                op_kind_o <= kind;
                op_addr_o <= addr_q;
            end
        end
    end

    always_comb
    begin
        status_byte_o = 8'h00;
        status_byte_o[ST_BUSY_BIT] = timer_busy;
        status_byte_o[ST_LATCH_BIT] = latch_q;
        status_byte_o[ST_GUARD_MSB:ST_GUARD_LSB] = guard_q;
        status_byte_o[ST_LOCK_BIT] = lock_q;
    end

    assign power_down_o = (mode_q == MODE_POWER_DOWN);

endmodule : sfcd_top

// ==== tb/sfcd_host.sv ====
// host serial controller model driving the link
`timescale 1ns/1ps
module sfcd_host (
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic so_i,
    input wire logic io0_i
);
    logic [0:79] rx_so;
    logic [0:79] rx_io;
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // clock runs only inside a frame
    task automatic xfer(input logic [79:0] tx, input int n, input realtime h);
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            mosi_o = tx[79-i];
            #(h) sclk_o = 1'b1;
            rx_so[i] = so_i;
            rx_io[i] = io0_i;
            #(h) sclk_o = 1'b0;
        end
        #25 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #45;
    endtask : xfer
endmodule : sfcd_host

// ==== tb/sfcd_top_sva.sv ====
// assertions on the ports of the command decoder
`timescale 1ns/1ps
module sfcd_top_sva (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic cs_n_i,
    input wire logic io0_oe_o,
    input wire logic serial_out_oe_o,
    input wire logic op_start_o,
    input wire logic [7:0] status_byte_o,
    input wire logic power_down_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    // ****
    // write cycle launch and end, reserved status bits and link outputs
    // ****
    sequence s_launch;
        $rose(status_byte_o[0]) ##1 (status_byte_o[0] && !op_start_o);
    endsequence
    AST_LAUNCH: assert property (op_start_o |-> s_launch)
        else $error("busy not raised by start");
    AST_BUSY_HOLD: assert property (op_start_o |=> status_byte_o[0] [*8])
        else $error("busy too short");
    AST_ARMED: assert property (op_start_o |-> status_byte_o[1])
        else $error("start without latch");
    AST_AFTER_CS: assert property (op_start_o |-> $past(cs_n_i, 1) && $past(cs_n_i, 2))
        else $error("start inside a frame");
    AST_DISARM: assert property ($fell(status_byte_o[0]) |-> ##[0:2] !status_byte_o[1])
        else $error("latch kept after cycle");
    AST_RSV_ZERO: assert property (status_byte_o[6:5] == 2'h0)
        else $error("reserved status bits set");
    AST_RELEASE: assert property (cs_n_i |-> !serial_out_oe_o && !io0_oe_o)
        else $error("driving while deselected");
    AST_DUAL: assert property (io0_oe_o |-> serial_out_oe_o)
        else $error("dual lanes not paired");
    AST_PD_QUIET: assert property (power_down_o |-> !op_start_o)
        else $error("start in power down");
endmodule : sfcd_top_sva
bind sfcd_top sfcd_top_sva u_sva (.clk_sys_i, .rst_b_i, .cs_n_i, .io0_oe_o, .serial_out_oe_o,
    .op_start_o, .status_byte_o, .power_down_o);

// ==== tb/tb_spi_flash_cmd_decoder.sv ====
// self-checking testbench of the serial flash command decoder
`timescale 1ns/1ps
module tb_spi_flash_cmd_decoder;
    import sfcd_pkg::*;
    localparam int T = 60;
    logic clk_sys_i, rst_b_i, sclk_i, cs_n_i, mosi, serial_in_i, io0_o, io0_oe_o;
    logic serial_out_o, serial_out_oe_o, op_start_o, power_down_o;
    logic [23:0] rd_addr_o, op_addr_o, a;
    logic [7:0] rd_data_i, status_byte_o, d;
    sfcd_op_e op_kind_o;
    logic [7:0] ops [6] = '{OP_PAGE_WRITE, OP_SECTOR_WIPE, OP_HALF_BLOCK_WIPE, OP_BLOCK_WIPE,
        OP_CHIP_WIPE_A, OP_CHIP_WIPE_B};
    sfcd_op_e kinds [6] = '{OPK_PAGE, OPK_SECTOR, OPK_HALF_BLOCK, OPK_BLOCK, OPK_CHIP, OPK_CHIP};
    int num_errors = 0, tests_run = 0, cyc = 0, starts = 0, s0;
    integer seed;
    realtime hp = 7.5;
    // shared IO0 wire; released lines read as pulled up
    assign serial_in_i = io0_oe_o ? io0_o : mosi;
    assign rd_data_i = exp_rd(rd_addr_o);
    sfcd_top #(.T_STATUS_CYC(T), .T_PAGE_CYC(T), .T_SECTOR_CYC(T), .T_BLOCK_CYC(T), .T_CHIP_CYC(T)) uut (
        .clk_sys_i, .rst_b_i, .sclk_i, .cs_n_i, .serial_in_i, .io0_o, .io0_oe_o, .serial_out_o,
        .serial_out_oe_o, .rd_addr_o, .rd_data_i, .op_start_o, .op_kind_o, .op_addr_o,
        .status_byte_o, .power_down_o);
    sfcd_host host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi),
        .so_i(serial_out_oe_o ? serial_out_o : 1'b1), .io0_i(io0_oe_o ? io0_o : 1'b1));
    function automatic logic [7:0] exp_rd(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5A;
    endfunction : exp_rd
    function automatic logic [7:0] rx8(input int at);
        for (int i = 0; i < 8; i++)
            rx8[7-i] = host.rx_so[at+i];
    endfunction : rx8
    function automatic logic [7:0] rx2(input int at);
        for (int p = 0; p < 4; p++)
            {rx2[7-2*p], rx2[6-2*p]} = {host.rx_so[at+p], host.rx_io[at+p]};
    endfunction : rx2
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic frame(input logic [79:0] tx, input int n);
        #3;    // keeps select edges off the system clock's sampling edge
        host.xfer(tx, n, hp);
        repeat (6) @(posedge clk_sys_i);
    endtask : frame
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // generous ceiling: the whole run needs well under a tenth of it
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        starts <= starts + int'(op_start_o === 1'b1);
        if (cyc == 60000)
        begin
            num_errors++;
            conclude();
        end
    end
    initial
    begin
        rst_b_i = 1'b0;
        seed = 32'haf2c;
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk("status", 24'h0, 24'(status_byte_o));
        frame({OP_WRITE_ARM, 72'h0}, 8);
        chk("status", 24'h2, 24'(status_byte_o));
        frame({OP_WRITE_DISARM, 72'h0}, 8);
        chk("status", 24'h0, 24'(status_byte_o));
        d = 8'($random(seed)) & 8'h9C;
        frame({OP_STATUS_WRITE, d, 64'h0}, 16);
        chk("status", 24'h0, 24'(status_byte_o));
        frame({OP_WRITE_ARM, 72'h0}, 8);
        frame({OP_STATUS_WRITE, d, 64'h0}, 15);
        chk("status", 24'h2, 24'(status_byte_o));
        frame({OP_STATUS_WRITE, d, 64'h0}, 16);
        frame({OP_RD_STATUS, 72'h0}, 24);
        chk("poll", 24'(d | 8'h03), 24'(rx8(8)));
        chk("poll", 24'(d | 8'h03), 24'(rx8(16)));
        repeat (T) @(posedge clk_sys_i);
        chk("status", 24'(d), 24'(status_byte_o));
        $display("status tests done");
        for (int k = 0; k < 6; k++)
        begin
            a = 24'($random(seed));
            frame({OP_WRITE_ARM, 72'h0}, 8);
            s0 = starts;
            frame({ops[k], a, 8'($random(seed)), 40'h0}, k == 0 ? 40 : k < 4 ? 32 : 8);
            chk("starts", 24'(s0 + 1), 24'(starts));
            chk("kind", 24'(kinds[k]), 24'(op_kind_o));
            if (k < 4)
                chk("address", a, op_addr_o);
            frame({OP_WRITE_DISARM, 72'h0}, 8);
            chk("busy latch", 24'h3, 24'(status_byte_o[1:0]));
            repeat (T) @(posedge clk_sys_i);
            chk("done latch", 24'h0, 24'(status_byte_o[1:0]));
        end
        s0 = starts;
        frame({OP_SECTOR_WIPE, a, 48'h0}, 32);
        frame({OP_WRITE_ARM, 72'h0}, 8);
        frame({OP_SECTOR_WIPE, a, 48'h0}, 31);
        chk("starts", 24'(s0), 24'(starts));
        frame({OP_WRITE_DISARM, 72'h0}, 8);
        $display("program tests done");
        frame({OP_READ, a, 48'h0}, 37);
        frame({OP_READ, a, 48'h0}, 48);
        chk("read", {8'h0, exp_rd(a), exp_rd(a + 24'h1)}, {8'h0, rx8(32), rx8(40)});
        frame({OP_FAST_READ, a, 48'h0}, 48);
        chk("fast read", 24'(exp_rd(a)), 24'(rx8(40)));
        frame({OP_DUAL_READ, a, 48'h0}, 48);
        chk("dual read", {8'h0, exp_rd(a), exp_rd(a + 24'h1)}, {8'h0, rx2(40), rx2(44)});
        frame({OP_STD_ID, 72'h0}, 32);
        chk("jedec id", 24'hA14015, {rx8(8), rx8(16), rx8(24)});
        for (int k = 0; k < 2; k++)
        begin
            frame({OP_MFR_DEV_ID, 24'(k), 48'h0}, 48);
            chk("maker id", k ? 24'h7BA1 : 24'hA17B, {8'h0, rx8(32), rx8(40)});
        end
        frame({OP_UID_READ, a, 48'h0}, 64);
        chk("unique id", 24'h012345, {rx8(40), rx8(48), rx8(56)});
        frame({OP_RELEASE_ID, 72'h0}, 48);
        chk("device id", 24'h7B7B, {8'h0, rx8(32), rx8(40)});
        frame({OP_POWER_DOWN, 72'h0}, 8);
        frame({OP_WRITE_ARM, 72'h0}, 8);
        chk("power down", {23'h0, 1'h1}, {23'h0, power_down_o});
        chk("status", 24'(d), 24'(status_byte_o));
        frame({OP_RELEASE_ID, 72'h0}, 8);
        chk("power down", 24'h0, {23'h0, power_down_o});
        $display("read tests done");
        conclude();
    end
endmodule : tb_spi_flash_cmd_decoder
